// >>> rtl/acr_chan1_cfg.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// What this block does
// - Source code 0 selects differential input, 1 single-ended, 2 and 3 are reserved.
// - Coupling code 0 means AC-coupled, 1 DC-coupled, 2 and 3 are not used.
// - Full-scale bit 0 picks the high range and 1 picks half of it.
// - Bandwidth bit 0 selects audio bandwidth and 1 wide bandwidth.
// - A volume code of zero mutes the channel outright.
// - Volume code 1 is -80 dB, each code adds 0.5 dB, 161 is unity, 255 is +47 dB.
// - The volume register resets to the unity code A1 hex.
// - Fine gain steps 0.1 dB, code 0 is -0.8 dB, 8 is 0 dB, 15 is +0.7 dB.
// - The fine gain register resets to 80 hex, which is 0 dB.
// - The phase field delays the channel by that many modulator cycles, 0 to 63.
// - Path code 0 delays both paths, 1 analog only, 2 digital only, 3 unused.
// - The phase register resets to zero, no delay on both paths.
// - The input setup register resets to all zeros.
module acr_chan1_cfg (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Decoded configuration towards the analog front end
  output logic                   chan1_src_single_ended,
  output logic                   chan1_dc_coupled,
  output logic                   chan1_half_scale,
  output logic                   chan1_wide_band,
  // Digital path controls
  output logic                   chan1_mute,
  output logic signed [10:0]     chan1_volume_tenth_db,
  output logic signed [4:0]      chan1_fine_gain_tenth_db,
  output logic      [5:0]        chan1_ana_delay_cycles,
  output logic      [5:0]        chan1_dig_delay_cycles
);

  // Reset synchroniser: asserts at once, releases after two edges
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Register storage
  logic [7:0] input_setup_r;
  logic [7:0] volume_r;
  logic [7:0] fine_gain_r;
  logic [7:0] phase_delay_r;

  // Address decode
  wire logic hit_setup = reg_addr == acr_pkg::OFS_INPUT_SETUP;
  wire logic hit_vol   = reg_addr == acr_pkg::OFS_VOLUME;
  wire logic hit_fg    = reg_addr == acr_pkg::OFS_FINE_GAIN;
  wire logic hit_pd    = reg_addr == acr_pkg::OFS_PHASE_DELAY;

  // Reserved bits are masked so they keep their zero reset value
  wire logic [7:0] setup_nxt =
    reg_wdata & acr_pkg::WMASK_INPUT_SETUP;
  wire logic [7:0] fg_nxt =
    reg_wdata & acr_pkg::WMASK_FINE_GAIN;

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      input_setup_r <= acr_pkg::RST_INPUT_SETUP;
      volume_r      <= acr_pkg::RST_VOLUME;
      fine_gain_r   <= acr_pkg::RST_FINE_GAIN;
      phase_delay_r <= acr_pkg::RST_PHASE_DELAY;
    end else if (reg_wr) begin
      if (hit_setup) input_setup_r <= setup_nxt;
      if (hit_vol)   volume_r      <= reg_wdata;
      if (hit_fg)    fine_gain_r   <= fg_nxt;
      if (hit_pd)    phase_delay_r <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses read as zero
  logic [7:0] rdata_nxt;
  assign rdata_nxt = hit_setup ? input_setup_r :
                     hit_vol   ? volume_r      :
                     hit_fg    ? fine_gain_r   :
                     hit_pd    ? phase_delay_r : 8'h00;

  // Field extraction
  wire acr_pkg::acr_src_e  src_code =
    acr_pkg::acr_src_e'(input_setup_r[acr_pkg::SRC_LSB +: 2]);
  wire logic [1:0] cpl_code = input_setup_r[acr_pkg::CPL_LSB +: 2];
  wire logic [3:0] fg_code  = fine_gain_r[acr_pkg::FG_LSB +: 4];
  wire logic [5:0] pd_code  = phase_delay_r[acr_pkg::PD_LSB +: 6];
  wire acr_pkg::acr_path_e path_code =
    acr_pkg::acr_path_e'(phase_delay_r[acr_pkg::SEL_LSB +: 2]);

  // Reserved source and coupling codes fall back to the reset meaning
  wire logic se_nxt  = src_code == acr_pkg::ACR_SRC_SE;
  wire logic dc_nxt  = cpl_code == 2'b01;
  wire logic fs_nxt  = input_setup_r[acr_pkg::FS_BIT];
  wire logic bw_nxt  = input_setup_r[acr_pkg::BW_BIT];

  // Gain law in tenths of a dB; linear between points
  wire logic signed [10:0] vol_db_nxt =
    11'(($signed({3'b000, volume_r}) -
         $signed(11'(acr_pkg::VOL_UNITY))) *
        $signed(11'(acr_pkg::VOL_STEP_T)));
  wire logic signed [4:0] fg_db_nxt =
    5'($signed({1'b0, fg_code}) -
       $signed(5'(acr_pkg::FG_UNITY)));
  wire logic mute_nxt = volume_r == 8'h00;

  // Delay routing; the unused code 3 applies no delay, a safe choice
  logic ana_en;
  logic dig_en;
  always_comb begin
    unique case (path_code)
      acr_pkg::ACR_PATH_BOTH: begin
        ana_en = 1'b1;
        dig_en = 1'b1;
      end
      acr_pkg::ACR_PATH_ANA: begin
        ana_en = 1'b1;
        dig_en = 1'b0;
      end
      acr_pkg::ACR_PATH_DIG: begin
        ana_en = 1'b0;
        dig_en = 1'b1;
      end
      acr_pkg::ACR_PATH_RSV: begin
        ana_en = 1'b0;
        dig_en = 1'b0;
      end
    endcase
  end
  wire logic [5:0] ana_dly_nxt = ana_en ? pd_code : 6'h00;
  wire logic [5:0] dig_dly_nxt = dig_en ? pd_code : 6'h00;

  // Output flops: all outputs one cycle behind the registers
  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata                <= 8'h00;
      chan1_src_single_ended   <= 1'b0;
      chan1_dc_coupled         <= 1'b0;
      chan1_half_scale         <= 1'b0;
      chan1_wide_band          <= 1'b0;
      chan1_mute               <= 1'b0;
      chan1_volume_tenth_db    <= 11'sd0;
      chan1_fine_gain_tenth_db <= 5'sd0;
      chan1_ana_delay_cycles   <= 6'h00;
      chan1_dig_delay_cycles   <= 6'h00;
    end else begin
      reg_rdata                <= reg_rd ? rdata_nxt : 8'h00;
      chan1_src_single_ended   <= se_nxt;
      chan1_dc_coupled         <= dc_nxt;
      chan1_half_scale         <= fs_nxt;
      chan1_wide_band          <= bw_nxt;
      chan1_mute               <= mute_nxt;
      chan1_volume_tenth_db    <= vol_db_nxt;
      chan1_fine_gain_tenth_db <= fg_db_nxt;
      chan1_ana_delay_cycles   <= ana_dly_nxt;
      chan1_dig_delay_cycles   <= dig_dly_nxt;
    end
  end

  // Reserved bits must never hold anything but their reset zero
  AST_RSV_SETUP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    (input_setup_r & ~acr_pkg::WMASK_INPUT_SETUP) == 8'h00)
    else $error("reserved setup bits not zero");
  AST_RSV_FG: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    fine_gain_r[3:0] == 4'h0)
    else $error("reserved fine gain bits not zero");

  // Stores land at the write edge and hold until the next write
  AST_SET_WR: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup |=>
    input_setup_r == ($past(reg_wdata) & acr_pkg::WMASK_INPUT_SETUP))
    else $error("setup write not stored");
  AST_VOL_WR: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol |=> volume_r == $past(reg_wdata))
    else $error("volume write not stored");
  AST_FG_WR: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_fg |=> fine_gain_r[7:4] == $past(reg_wdata[7:4]))
    else $error("fine gain write not stored");
  AST_PD_WR: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_pd |=> phase_delay_r == $past(reg_wdata))
    else $error("phase write not stored");
  AST_SET_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    !reg_wr |=> $stable(input_setup_r))
    else $error("setup changed without a write");
  AST_VOL_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    !reg_wr |=> $stable(volume_r))
    else $error("volume changed without a write");
  AST_FG_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    !reg_wr |=> $stable(fine_gain_r))
    else $error("fine gain changed without a write");
  AST_PD_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    !reg_wr |=> $stable(phase_delay_r))
    else $error("phase changed without a write");

  // Input setup decode shows two edges after the write
  AST_SE: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup |=> ##1
    chan1_src_single_ended == ($past(reg_wdata[7:6], 2) == 2'b01))
    else $error("source decode wrong");
  AST_DIFF: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup && reg_wdata[7:6] == 2'b00 |=> ##1
    !chan1_src_single_ended)
    else $error("differential source not decoded");
  AST_DC: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup |=> ##1
    chan1_dc_coupled == ($past(reg_wdata[3:2], 2) == 2'b01))
    else $error("coupling decode wrong");
  AST_AC: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup && reg_wdata[3:2] == 2'b00 |=> ##1
    !chan1_dc_coupled)
    else $error("AC coupling not decoded");
  AST_HS: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup |=> ##1
    chan1_half_scale == $past(reg_wdata[1], 2))
    else $error("full-scale select wrong");
  AST_FS_LVL: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    chan1_half_scale == $past(input_setup_r[acr_pkg::FS_BIT]))
    else $error("full-scale output lost its register");
  AST_WB: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_setup |=> ##1
    chan1_wide_band == $past(reg_wdata[0], 2))
    else $error("bandwidth select wrong");

  // Volume law at its end points, unity and one step above unity
  AST_MUTE: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol && reg_wdata == 8'h00 |=> ##1 chan1_mute)
    else $error("zero volume did not mute");
  AST_UNMUTE: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol && reg_wdata != 8'h00 |=> ##1 !chan1_mute)
    else $error("nonzero volume muted");
  AST_MUTE_LVL: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    chan1_mute == ($past(volume_r) == 8'h00))
    else $error("mute does not follow volume");
  AST_VOL_UNITY: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol && reg_wdata == 8'hA1 |=> ##1
    chan1_volume_tenth_db == 11'sd0)
    else $error("unity volume code wrong");
  AST_VOL_MIN: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol && reg_wdata == 8'h01 |=> ##1
    chan1_volume_tenth_db == -11'sd800)
    else $error("minimum volume code wrong");
  AST_VOL_MAX: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol && reg_wdata == 8'hFF |=> ##1
    chan1_volume_tenth_db == 11'sd470)
    else $error("maximum volume code wrong");
  AST_VOL_HALF: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_vol && reg_wdata == 8'hA2 |=> ##1
    chan1_volume_tenth_db == 11'sd5)
    else $error("half dB volume step wrong");

  // Fine gain law
  AST_FG_LAW: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_fg |=> ##1
    chan1_fine_gain_tenth_db == $signed({1'b0, $past(reg_wdata[7:4], 2)})
    - 5'sd8)
    else $error("fine gain law wrong");
  AST_FG_MIN: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_fg && reg_wdata[7:4] == 4'h0 |=> ##1
    chan1_fine_gain_tenth_db == -5'sd8)
    else $error("minimum fine gain wrong");
  AST_FG_MAX: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_fg && reg_wdata[7:4] == 4'hF |=> ##1
    chan1_fine_gain_tenth_db == 5'sd7)
    else $error("maximum fine gain wrong");

  // Delay routing per path selector
  AST_PATH_ANA: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_pd && reg_wdata[1:0] == 2'b01 |=> ##1
    chan1_dig_delay_cycles == 6'h00 &&
    chan1_ana_delay_cycles == $past(reg_wdata[7:2], 2))
    else $error("analog-only delay routing wrong");
  AST_PATH_DIG: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_pd && reg_wdata[1:0] == 2'b10 |=> ##1
    chan1_ana_delay_cycles == 6'h00 &&
    chan1_dig_delay_cycles == $past(reg_wdata[7:2], 2))
    else $error("digital-only delay routing wrong");
  AST_PATH_BOTH: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_pd && reg_wdata[1:0] == 2'b00 |=> ##1
    chan1_dig_delay_cycles == chan1_ana_delay_cycles)
    else $error("both-path delay routing wrong");
  AST_PD_VAL: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_pd && reg_wdata[1:0] == 2'b00 |=> ##1
    chan1_ana_delay_cycles == $past(reg_wdata[7:2], 2))
    else $error("both-path delay count wrong");

  // Read port: data stands one cycle after the strobe, zero otherwise
  AST_RD: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_rd && hit_vol |=> reg_rdata == volume_r)
    else $error("volume readback wrong");
  AST_RD_SETUP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_rd && hit_setup |=> reg_rdata == input_setup_r)
    else $error("setup readback wrong");
  AST_RD_FG: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_rd && hit_fg |=> reg_rdata == fine_gain_r)
    else $error("fine gain readback wrong");
  AST_RD_PD: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_rd && hit_pd |=> reg_rdata == phase_delay_r)
    else $error("phase readback wrong");
  AST_RD_UNMAP: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    reg_rd && !(hit_setup || hit_vol || hit_fg || hit_pd) |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_IDLE_RD: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_r)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero when idle");

  // Main scenarios worth seeing once
  COV_MUTE: cover property (@(posedge sys_clk) disable iff (!rst_sync_r)
    $rose(chan1_mute));
  COV_DIG: cover property (@(posedge sys_clk) disable iff (!rst_sync_r)
    chan1_dig_delay_cycles == 6'h3F && chan1_ana_delay_cycles == 6'h00);
  COV_WIDE: cover property (@(posedge sys_clk) disable iff (!rst_sync_r)
    chan1_wide_band && chan1_half_scale);
  COV_RDWR: cover property (@(posedge sys_clk) disable iff (!rst_sync_r)
    reg_wr && hit_fg ##1 reg_rd && hit_fg);
  COV_UNITY: cover property (@(posedge sys_clk) disable iff (!rst_sync_r)
    chan1_volume_tenth_db == 11'sd0 && !chan1_mute);

endmodule : acr_chan1_cfg

// >>> rtl/acr_pkg.sv
package acr_pkg;
  // Register offsets (byte addresses on the control port)
  localparam logic [7:0] OFS_INPUT_SETUP = 8'h50;
  localparam logic [7:0] OFS_VOLUME      = 8'h52;
  localparam logic [7:0] OFS_FINE_GAIN   = 8'h53;
  localparam logic [7:0] OFS_PHASE_DELAY = 8'h54;
  // Reset values
  localparam logic [7:0] RST_INPUT_SETUP = 8'h00;
  localparam logic [7:0] RST_VOLUME      = 8'hA1;
  localparam logic [7:0] RST_FINE_GAIN   = 8'h80;
  localparam logic [7:0] RST_PHASE_DELAY = 8'h00;
  // Writable bit masks; other bits are reserved and read as zero
  localparam logic [7:0] WMASK_INPUT_SETUP = 8'hCF;
  localparam logic [7:0] WMASK_FINE_GAIN   = 8'hF0;
  // Field positions
  localparam int SRC_LSB   = 6;
  localparam int CPL_LSB   = 2;
  localparam int FS_BIT    = 1;
  localparam int BW_BIT    = 0;
  localparam int FG_LSB    = 4;
  localparam int PD_LSB    = 2;
  localparam int SEL_LSB   = 0;
  // Gain law in tenths of a dB
  localparam int VOL_UNITY   = 161;
  localparam int VOL_STEP_T  = 5;
  localparam int FG_UNITY    = 8;
  localparam int FG_STEP_T   = 1;
  // Input source codes
  typedef enum logic [1:0] {
    ACR_SRC_DIFF = 2'b00,
    ACR_SRC_SE   = 2'b01,
    ACR_SRC_RSV2 = 2'b10,
    ACR_SRC_RSV3 = 2'b11
  } acr_src_e;
  // Delay path codes
  typedef enum logic [1:0] {
    ACR_PATH_BOTH = 2'b00,
    ACR_PATH_ANA  = 2'b01,
    ACR_PATH_DIG  = 2'b10,
    ACR_PATH_RSV  = 2'b11
  } acr_path_e;
endpackage : acr_pkg

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } acr_row_s;
  // Bench side of the register port and observed outputs
  logic               sys_clk;
  logic               rst_b;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic [7:0]         reg_rdata;
  logic [7:0]         rv;
  logic               se, dc, hs, wb, mu;
  logic signed [10:0] vol;
  logic signed [4:0]  fg;
  logic [5:0]         ad, dd;
  logic [7:0]         sh [5];
  acr_row_s           rows [17];
  int                 n_mismatch = 0;
  int                 samples_checked = 0;

  acr_chan1_cfg dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan1_src_single_ended(se),
    .chan1_dc_coupled(dc), .chan1_half_scale(hs), .chan1_wide_band(wb),
    .chan1_mute(mu), .chan1_volume_tenth_db(vol),
    .chan1_fine_gain_tenth_db(fg), .chan1_ana_delay_cycles(ad),
    .chan1_dig_delay_cycles(dd));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : chk

  // Bus tasks are entered right at a rising edge; writes may chain into reads
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  // Expected decoded outputs worked out from the shadow copy of the registers
  task automatic chk_out();
    logic [1:0] sel;
    logic [5:0] pd;
    sel = sh[4][1:0];
    pd = sh[4][7:2];
    chk(se, sh[0][7:6] == 2'h1, "source");
    chk(dc, sh[0][3:2] == 2'h1, "coupling");
    chk(hs, sh[0][1], "full scale");
    chk(wb, sh[0][0], "bandwidth");
    chk(mu, sh[2] == 8'h00, "mute");
    if (sh[2] != 8'h00) chk(vol, (int'(sh[2]) - 161) * 5, "vol");
    chk(fg, int'(sh[3][7:4]) - 8, "fine gain");
    chk(ad, (sel == 2'h0 || sel == 2'h1) ? pd : 6'h00, "ana");
    chk(dd, (sel == 2'h0 || sel == 2'h2) ? pd : 6'h00, "dig");
  endtask : chk_out

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Guard against a hung run
  initial begin
    #500000;
    $display("run limit reached");
    n_mismatch++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    // Host keeps reserved codes and reserved bits out of every write
    rows = '{'{8'h50, 8'h47, 8'h47}, '{8'h50, 8'h44, 8'h44},
      '{8'h50, 8'h06, 8'h06}, '{8'h50, 8'h01, 8'h01}, '{8'h52, 8'h00, 8'h00},
      '{8'h52, 8'h01, 8'h01}, '{8'h52, 8'hFF, 8'hFF}, '{8'h52, 8'hA2, 8'hA2},
      '{8'h52, 8'hA1, 8'hA1},
      '{8'h53, 8'h00, 8'h00}, '{8'h53, 8'hF0, 8'hF0}, '{8'h53, 8'h90, 8'h90},
      '{8'h54, 8'hFC, 8'hFC}, '{8'h54, 8'h05, 8'h05}, '{8'h54, 8'hFE, 8'hFE},
      '{8'h54, 8'h0D, 8'h0D}, '{8'h54, 8'h00, 8'h00}};
    sh = '{8'h00, 8'h00, 8'hA1, 8'h80, 8'h00};
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk_out();
    for (int k = 0; k < 5; k++) begin
      if (k == 1) continue;
      @(posedge sys_clk);
      rd(8'h50 + 8'(k));
      chk(rv, sh[k], "reset value");
    end
    $display("reset values test done");
    // Each row: write, read back at once, then the decoded outputs
    foreach (rows[i]) begin
      @(posedge sys_clk);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(rv, rows[i].r, "readback");
      sh[rows[i].a[2:0]] = rows[i].r;
      chk_out();
    end
    $display("row table test done");
    // Unmapped places neither store nor disturb anything
    @(posedge sys_clk);
    wr(8'h51, 8'hFF);
    rd(8'h51);
    chk(rv, 8'h00, "unmapped 51");
    @(posedge sys_clk);
    rd(8'h55);
    chk(rv, 8'h00, "unmapped 55");
    chk_out();
    $display("unmapped test done");
    // Second reset in mid-run restores the reset values
    @(posedge sys_clk);
    rst_b <= 1'b0;
    #1 chk(mu, 1'b0, "mute in reset");
    chk(vol, 11'h000, "vol in reset");
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h52);
    chk(rv, 8'hA1, "volume after reset");
    @(posedge sys_clk);
    rd(8'h53);
    chk(rv, 8'h80, "fine gain after reset");
    @(posedge sys_clk);
    rd(8'h50);
    chk(rv, 8'h00, "setup after reset");
    sh = '{8'h00, 8'h00, 8'hA1, 8'h80, 8'h00};
    chk_out();
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule : tb_top
